// File: cel_sync.sv
// Functional notes
// [RL1] Bit 15 enables comparator; resets clear.
// [RL2] Result true when noninverting exceeds inverting.
// [RL3] Enabled: branch condition follows comparator result.
// [RL4] Disabled: branch condition follows condition pin.
// [RL5] Enabled: result rising raises rise event.
// [RL6] Enabled: result falling raises fall event.
// [RL7] Rising stops timer if fall flag, enable clear.
// [RL8] Falling starts timer if rise flag and enable clear.
// [RL9] Rise event sets flag bit 6; mask 6.
// [RL10] Rise flag clears on rise vector branch.
// [RL11] Fall flag bit 7, mask 7, branch clears.
// [RL12] Software may set or clear both flags.
// [RL13] Bit 10 starts and stops first timer.
// [RL14] Disabled: pin edges raise events; timer software.
// [RL15] Enabled: pins are comparator inputs, not GPIO.
// [RL16] Software keeps both pins inputs while enabled.
// [RL17] Comparator synchronised twice; one-cycle edge events.
package cel_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  // Register offsets on the I/O port.
  localparam logic [7:0] PORTD_DIR_OFS = 8'h1C;
  localparam logic [7:0] PORTD_OUT_OFS = 8'h1D;
  localparam logic [7:0] GEN_CTRL_OFS = 8'h38;
  localparam logic [7:0] IFR_OFS = 8'h39;
  localparam logic [7:0] STATUS_OFS = 8'h3A;
  // Field positions.
  localparam int unsigned CMP_EN_BIT = 15;
  localparam int unsigned TMR1_EN_BIT = 10;
  localparam int unsigned RISE_BIT = 6;
  localparam int unsigned FALL_BIT = 7;
  localparam int unsigned INV_PIN_BIT = 4;
  localparam int unsigned NONINV_PIN_BIT = 5;
  localparam int unsigned ST_CMP_BIT = 0;
  localparam int unsigned ST_HWRUN_BIT = 1;
  localparam int unsigned ST_TMRRUN_BIT = 2;
  // Reset values.
  localparam logic [15:0] GEN_CTRL_RST = 16'h0000;
  localparam logic [7:0] PORTD_DIR_RST = 8'h00;
  localparam logic [7:0] PORTD_OUT_RST = 8'h00;
  localparam logic [1:0] FLAGS_RST = 2'h0;
endpackage

// Two-flop synchroniser bank with rise and fall pulses per bit.
module cel_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise_pulse,
  output logic [W-1:0] fall_pulse
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // The first stage is read only by the second stage.
  // [RL17] two flop sync
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges compare the synchronised value with its previous sample.
  // [RL17] single cycle edges
  assign sync_out = sync_q;
  assign rise_pulse = sync_q & ~prev_q & {W{ce}};
  assign fall_pulse = ~sync_q & prev_q & {W{ce}};
endmodule

// File: cel_top.sv
// Comparator event logic: comparator sense, branch condition, edge
// interrupts and comparator-driven start and stop of the first timer.
module cel_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // I/O port register access.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Analog comparator.
  input wire logic cmp_out_raw,
  output logic cmp_power_en,
  // Shared port pins and the condition pin.
  input wire logic inverting_input_pin_i,
  output logic inverting_input_pin_o,
  output logic inverting_input_pin_oe,
  input wire logic noninverting_input_pin_i,
  output logic noninverting_input_pin_o,
  output logic noninverting_input_pin_oe,
  input wire logic condition_pin_i,
  // CPU side.
  input wire logic rise_vector_taken,
  input wire logic fall_vector_taken,
  output logic comparator_condition,
  output logic rise_interrupt_req,
  output logic fall_interrupt_req,
  output logic first_timer_run
);
  logic [15:0] gen_ctrl_q;
  logic [7:0] portd_dir_q;
  logic [7:0] portd_out_q;
  logic rise_flag_q;
  logic fall_flag_q;
  logic hw_run_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [3:0] async_vec;
  logic [3:0] sync_vec;
  logic [3:0] rise_vec;
  logic [3:0] fall_vec;
  logic cmp_en;
  logic tmr_en;
  logic cmp_true;
  logic cmp_rise;
  logic cmp_fall;
  logic rise_event;
  logic fall_event;
  logic timer_stop;
  logic timer_start;
  logic wr_gen;
  logic wr_ifr;
  logic wr_dir;
  logic wr_out;

  // One synchroniser bank for the comparator and the three pins.
  assign async_vec = {condition_pin_i, noninverting_input_pin_i, inverting_input_pin_i, cmp_out_raw};

  cel_sync #(
    .W(4)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(async_vec),
    .sync_out(sync_vec),
    .rise_pulse(rise_vec),
    .fall_pulse(fall_vec)
  );

  // Write decode for each register.
  assign wr_gen = reg_wr && (reg_addr == cel_pkg::GEN_CTRL_OFS);
  assign wr_ifr = reg_wr && (reg_addr == cel_pkg::IFR_OFS);
  assign wr_dir = reg_wr && (reg_addr == cel_pkg::PORTD_DIR_OFS);
  assign wr_out = reg_wr && (reg_addr == cel_pkg::PORTD_OUT_OFS);

  // General control register; all bits stored, reset to zero.
  // [RL1] enable resets clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_ctrl_q <= cel_pkg::GEN_CTRL_RST;
    end else if (ce && wr_gen) begin
      gen_ctrl_q <= reg_wdata;
    end
  end

  // Port D direction and output data for the shared pins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      portd_dir_q <= cel_pkg::PORTD_DIR_RST;
      portd_out_q <= cel_pkg::PORTD_OUT_RST;
    end else if (ce) begin
      if (wr_dir) begin
        portd_dir_q <= reg_wdata[7:0];
      end
      if (wr_out) begin
        portd_out_q <= reg_wdata[7:0];
      end
    end
  end

  assign cmp_en = gen_ctrl_q[cel_pkg::CMP_EN_BIT];
  assign tmr_en = gen_ctrl_q[cel_pkg::TMR1_EN_BIT];

  // The analog comparator is wired with the noninverting pin on its
  // positive input, so a high output means that pin is the higher one.
  // [RL2] comparator polarity
  assign cmp_true = sync_vec[0];
  assign cmp_power_en = cmp_en;

  // Branch condition source follows the enable bit.
  // [RL3] condition from comparator
  // [RL4] condition from pin
  assign comparator_condition = cmp_en ? cmp_true : sync_vec[3];

  // Comparator transitions only count while the comparator is on.
  // [RL5] rise on transition
  assign cmp_rise = cmp_en && rise_vec[0];
  // [RL6] fall on transition
  assign cmp_fall = cmp_en && fall_vec[0];

  // With the comparator off the pin edges take over the two events.
  // [RL14] pin edge events
  assign rise_event = cmp_en ? cmp_rise : rise_vec[1];
  assign fall_event = cmp_en ? cmp_fall : fall_vec[2];

  // Timer control uses the flags as they stood before the transition.
  // [RL7] stop on rise
  assign timer_stop = cmp_rise && fall_flag_q && !tmr_en;
  // [RL8] start on fall
  assign timer_start = cmp_fall && !rise_flag_q && !tmr_en;

  // Rise flag: an event wins over a vector clear or software write.
  // [RL9] set rise flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_flag_q <= cel_pkg::FLAGS_RST[0];
    end else if (ce) begin
      if (rise_event) begin
        rise_flag_q <= 1'b1;
      end else if (wr_ifr) begin
        // [RL12] software flag write
        rise_flag_q <= reg_wdata[cel_pkg::RISE_BIT];
      end else if (rise_vector_taken) begin
        // [RL10] clear on branch
        rise_flag_q <= 1'b0;
      end
    end
  end

  // Fall flag, same precedence as the rise flag.
  // [RL11] fall flag handling
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_flag_q <= cel_pkg::FLAGS_RST[1];
    end else if (ce) begin
      if (fall_event) begin
        fall_flag_q <= 1'b1;
      end else if (wr_ifr) begin
        // [RL12] software flag write
        fall_flag_q <= reg_wdata[cel_pkg::FALL_BIT];
      end else if (fall_vector_taken) begin
        fall_flag_q <= 1'b0;
      end
    end
  end

  // Interrupt requests are flag and mask bit together.
  // [RL9] rise mask gate
  assign rise_interrupt_req = rise_flag_q && gen_ctrl_q[cel_pkg::RISE_BIT];
  // [RL11] fall mask gate
  assign fall_interrupt_req = fall_flag_q && gen_ctrl_q[cel_pkg::FALL_BIT];

  // Hardware run state for comparator start and stop. Any write to the
  // general control register hands the timer back to software, and so
  // does switching the comparator off.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_run_q <= 1'b0;
    end else if (ce) begin
      if (wr_gen || !cmp_en) begin
        hw_run_q <= 1'b0;
      end else if (timer_start) begin
        hw_run_q <= 1'b1;
      end else if (timer_stop) begin
        hw_run_q <= 1'b0;
      end
    end
  end

  // Enable bit runs the timer; otherwise the hardware state does.
  // [RL13] software timer enable
  assign first_timer_run = tmr_en || hw_run_q;

  // Shared pins drive only while the comparator is off and the
  // direction bit selects output; this also protects against contention.
  // [RL15] pins released when enabled
  assign inverting_input_pin_oe = !cmp_en && portd_dir_q[cel_pkg::INV_PIN_BIT];
  assign noninverting_input_pin_oe = !cmp_en && portd_dir_q[cel_pkg::NONINV_PIN_BIT];
  assign inverting_input_pin_o = portd_out_q[cel_pkg::INV_PIN_BIT];
  assign noninverting_input_pin_o = portd_out_q[cel_pkg::NONINV_PIN_BIT];

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rdata_d = 16'h0000;
    unique case (reg_addr)
      cel_pkg::GEN_CTRL_OFS: begin
        rdata_d = gen_ctrl_q;
      end
      cel_pkg::IFR_OFS: begin
        rdata_d[cel_pkg::RISE_BIT] = rise_flag_q;
        rdata_d[cel_pkg::FALL_BIT] = fall_flag_q;
      end
      cel_pkg::PORTD_DIR_OFS: begin
        rdata_d = {8'h00, portd_dir_q};
      end
      cel_pkg::PORTD_OUT_OFS: begin
        rdata_d = {8'h00, portd_out_q};
      end
      cel_pkg::STATUS_OFS: begin
        rdata_d[cel_pkg::ST_CMP_BIT] = cmp_true;
        rdata_d[cel_pkg::ST_HWRUN_BIT] = hw_run_q;
        rdata_d[cel_pkg::ST_TMRRUN_BIT] = first_timer_run;
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      rdata_q <= reg_rd ? rdata_d : 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// File: cel_analog_model.sv
// Analog far side: two pin voltages feeding the comparator.
module cel_analog_model (
  input wire logic [7:0] v_pos,
  input wire logic [7:0] v_neg,
  output logic cmp_out_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  // positive above negative
  // The result is high only while the positive input is strictly above the negative one.
  assign cmp_out_raw = v_pos > v_neg;
endmodule

// File: cel_chk_sva.sv
// Port-level checker for the comparator event logic.
module cel_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic cmp_out_raw,
  input wire logic cmp_power_en,
  input wire logic inverting_input_pin_i,
  input wire logic inverting_input_pin_oe,
  input wire logic noninverting_input_pin_i,
  input wire logic noninverting_input_pin_oe,
  input wire logic condition_pin_i,
  input wire logic rise_vector_taken,
  input wire logic fall_vector_taken,
  input wire logic comparator_condition,
  input wire logic rise_interrupt_req,
  input wire logic fall_interrupt_req,
  input wire logic first_timer_run
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Write to the general control register.
  logic gwr;
  assign gwr = reg_wr && ce && (reg_addr == cel_pkg::GEN_CTRL_OFS);
  // Four cycles with no source of a hardware event, so no edge pulse is pending.
  sequence s_quiet;
    ($stable(cmp_out_raw) && $stable(inverting_input_pin_i) && $stable(noninverting_input_pin_i)
      && $stable(cmp_power_en) && ce)[*4];
  endsequence
  property p_rst_off;
    $rose(rst_n) |-> !cmp_power_en;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("comparator enabled out of reset");
  property p_en_wr;
    gwr && reg_wdata[15] |=> cmp_power_en;
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable bit write not taken");
  property p_oe;
    cmp_power_en |-> !inverting_input_pin_oe && !noninverting_input_pin_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("shared pin driven while comparator on");
  property p_cond_en;
    (cmp_power_en && ce && $stable(cmp_out_raw))[*4] |-> comparator_condition == cmp_out_raw;
  endproperty
  a_cond_en: assert property (p_cond_en) else $error("condition not following comparator");
  property p_cond_dis;
    (!cmp_power_en && ce && $stable(condition_pin_i))[*4] |-> comparator_condition == condition_pin_i;
  endproperty
  a_cond_dis: assert property (p_cond_dis) else $error("condition not following pin");
  property p_vec_r;
    s_quiet ##0 (rise_vector_taken && !reg_wr) |=> !rise_interrupt_req;
  endproperty
  a_vec_r: assert property (p_vec_r) else $error("rise flag kept after vector");
  property p_vec_f;
    s_quiet ##0 (fall_vector_taken && !reg_wr) |=> !fall_interrupt_req;
  endproperty
  a_vec_f: assert property (p_vec_f) else $error("fall flag kept after vector");
  property p_tmr_on;
    gwr && reg_wdata[10] |=> first_timer_run;
  endproperty
  a_tmr_on: assert property (p_tmr_on) else $error("timer not started by software");
  property p_tmr_off;
    gwr && (reg_wdata[15:10] == 6'h00) && !cmp_power_en |=> !first_timer_run;
  endproperty
  a_tmr_off: assert property (p_tmr_off) else $error("timer not stopped by software");
endmodule
bind cel_top cel_chk cel_chk_i (.core_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .cmp_out_raw,
  .cmp_power_en, .inverting_input_pin_i, .inverting_input_pin_oe, .noninverting_input_pin_i,
  .noninverting_input_pin_oe, .condition_pin_i, .rise_vector_taken, .fall_vector_taken,
  .comparator_condition, .rise_interrupt_req, .fall_interrupt_req, .first_timer_run);

// File: tb_top.sv
// Self-checking bench for the comparator event logic.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic condition_pin_i = 1'b0;
  logic inverting_input_pin_i = 1'b0;
  logic noninverting_input_pin_i = 1'b0;
  logic rise_vector_taken = 1'b0;
  logic fall_vector_taken = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [7:0] vp = 8'h00;
  logic [7:0] vn = 8'h00;
  logic [15:0] reg_rdata;
  logic cmp_out_raw, cmp_power_en, comparator_condition, rise_interrupt_req, fall_interrupt_req, first_timer_run;
  logic inverting_input_pin_o, inverting_input_pin_oe, noninverting_input_pin_o, noninverting_input_pin_oe;
  int fails = 0;
  int n_checks = 0;
  cel_top cel_top_i (.core_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_out_raw,
    .cmp_power_en, .inverting_input_pin_i, .inverting_input_pin_o, .inverting_input_pin_oe,
    .noninverting_input_pin_i, .noninverting_input_pin_o, .noninverting_input_pin_oe, .condition_pin_i,
    .rise_vector_taken, .fall_vector_taken, .comparator_condition, .rise_interrupt_req,
    .fall_interrupt_req, .first_timer_run);
  cel_analog_model cel_analog_model_i (.v_pos(vp), .v_neg(vn), .cmp_out_raw);
  // Clock of 100 ns period.
  always #50 core_clk = ~core_clk;
  // Compares for words and for single bits.
  task automatic chkw(input string n, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic s);
    chkw(n, {15'h0000, e}, {15'h0000, s});
  endtask
  // Waits some edges, then a settle step so edge updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chkw(n, e, reg_rdata);
  endtask
  // Moves the analog inputs and waits for the synchroniser.
  task automatic ana(input logic [7:0] p, input logic [7:0] q);
    @(posedge core_clk);
    vp <= p;
    vn <= q;
    cyc(6);
  endtask
  function automatic logic exp_cmp(input logic [7:0] p, input logic [7:0] q);
    return p > q;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog sized well above the expected run of a few hundred cycles.
  initial begin
    #(100 * 4000);
    fails++;
    tally_and_finish();
  end
  initial begin
    logic c;
    logic [7:0] p;
    logic [7:0] q;
    void'($urandom(32'h4BDF));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(cel_pkg::GEN_CTRL_OFS, 16'h0000, "ctl");
    rd(8'h05, 16'h0000, "unmapped");
    for (int i = 0; i < 8; i++) begin
      c = 1'($urandom());
      @(posedge core_clk);
      condition_pin_i <= c;
      cyc(5);
      chkb("cond_pin", c, comparator_condition);
    end
    // With the comparator off the shared pins behave as plain outputs.
    wr(cel_pkg::PORTD_DIR_OFS, 16'h0030);
    wr(cel_pkg::PORTD_OUT_OFS, 16'h0010);
    cyc(1);
    chkb("inv_oe", 1'b1, inverting_input_pin_oe);
    chkb("noninv_oe", 1'b1, noninverting_input_pin_oe);
    chkb("inv_o", 1'b1, inverting_input_pin_o);
    chkb("noninv_o", 1'b0, noninverting_input_pin_o);
    rd(cel_pkg::PORTD_DIR_OFS, 16'h0030, "dir");
    // Both shared pins go back to inputs before the comparator is ever enabled.
    wr(cel_pkg::PORTD_DIR_OFS, 16'h0000);
    cyc(1);
    chkb("inv_rel", 1'b0, inverting_input_pin_oe);
    chkb("noninv_rel", 1'b0, noninverting_input_pin_oe);
    wr(cel_pkg::GEN_CTRL_OFS, 16'h00C0);
    @(posedge core_clk);
    inverting_input_pin_i <= 1'b1;
    noninverting_input_pin_i <= 1'b1;
    cyc(6);
    chkb("pin_rise", 1'b1, rise_interrupt_req);
    chkb("no_fall", 1'b0, fall_interrupt_req);
    @(posedge core_clk);
    noninverting_input_pin_i <= 1'b0;
    cyc(6);
    chkb("pin_fall", 1'b1, fall_interrupt_req);
    rd(cel_pkg::IFR_OFS, 16'h00C0, "ifr");
    @(posedge core_clk);
    rise_vector_taken <= 1'b1;
    fall_vector_taken <= 1'b1;
    @(posedge core_clk);
    rise_vector_taken <= 1'b0;
    fall_vector_taken <= 1'b0;
    cyc(1);
    chkb("vec_rise", 1'b0, rise_interrupt_req);
    chkb("vec_fall", 1'b0, fall_interrupt_req);
    wr(cel_pkg::IFR_OFS, 16'h00C0);
    rd(cel_pkg::IFR_OFS, 16'h00C0, "ifr_set");
    wr(cel_pkg::IFR_OFS, 16'h0000);
    rd(cel_pkg::IFR_OFS, 16'h0000, "ifr_clr");
    wr(cel_pkg::GEN_CTRL_OFS, 16'h0400);
    cyc(1);
    chkb("tmr_sw_on", 1'b1, first_timer_run);
    wr(cel_pkg::GEN_CTRL_OFS, 16'h0000);
    ana(8'h20, 8'h10);
    rd(cel_pkg::IFR_OFS, 16'h0000, "off_rise");
    wr(cel_pkg::GEN_CTRL_OFS, 16'h80C0);
    cyc(1);
    chkb("cmp_pwr", 1'b1, cmp_power_en);
    chkb("en_oe", 1'b0, inverting_input_pin_oe);
    for (int i = 0; i < 8; i++) begin
      p = 8'($urandom());
      q = 8'($urandom());
      ana(p, q);
      chkb("cmp", exp_cmp(p, q), comparator_condition);
    end
    ana(8'h00, 8'h01);
    wr(cel_pkg::IFR_OFS, 16'h0000);
    wr(cel_pkg::GEN_CTRL_OFS, 16'h80C0);
    ana(8'h02, 8'h01);
    chkb("cmp_rise", 1'b1, rise_interrupt_req);
    wr(cel_pkg::IFR_OFS, 16'h0000);
    ana(8'h00, 8'h01);
    chkb("hw_start", 1'b1, first_timer_run);
    chkb("cmp_fall", 1'b1, fall_interrupt_req);
    rd(cel_pkg::STATUS_OFS, 16'h0006, "status");
    ana(8'h02, 8'h01);
    chkb("hw_stop", 1'b0, first_timer_run);
    ana(8'h00, 8'h01);
    chkb("no_start", 1'b0, first_timer_run);
    tally_and_finish();
  end
endmodule
